// ===== logic/lpt_regs.svh
`ifndef LPT_REGS_SVH
`define LPT_REGS_SVH
// register offsets
`define LPT_REG_CTRL      8'h00
`define LPT_REG_CHAN      8'h04
`define LPT_REG_CMD       8'h08
`define LPT_REG_ERRS      8'h0c
`define LPT_REG_STAT      8'h10
// register fields
`define LPT_CTRL_LOC_LSB  0
`define LPT_CTRL_REM_LSB  2
`define LPT_CTRL_PAT_LSB  5
`define LPT_CTRL_DTE_BIT  8
`define LPT_CTRL_R64_BIT  9
`define LPT_CTRL_FRAC_BIT 10
`define LPT_CHAN_ST_LSB   0
`define LPT_CHAN_N_LSB    8
`define LPT_CMD_CLR_BIT   0
`define LPT_CMD_INS_BIT   1
`define LPT_CMD_ST_BIT    2
`define LPT_STAT_BUSY_BIT 0
`define LPT_STAT_FAIL_LSB 1
`define LPT_STAT_SYNC_BIT 4
`define LPT_STAT_RATE_LSB 8
// reset values
`define LPT_RST_START     5'h01
`define LPT_RST_NCHAN     5'h18
// frame and checker figures
`define LPT_LAST_POS      8'hc0
`define LPT_NUM_CHAN      5'h18
`define LPT_SYNC_GOOD     5'h0f
`define LPT_SYNC_LOSS     5'h08
`define LPT_REL_FRAMES    8'hc8
// remote loop code words
`define LPT_INB_UP        8'h84
`define LPT_INB_DN        8'h92
`define LPT_V54_UP        8'hf0
`define LPT_V54_DN        8'h0f
`define LPT_FDL_LLB_UP    16'h0e7e
`define LPT_FDL_PLB_UP    16'h287e
`define LPT_FDL_DN        16'h387e
// timing
`define LPT_CLK_MHZ       250
`define LPT_ST_TIME_MS    5000
`define LPT_ST_CYCLES     (64'd5000 * 64'd1000 * 64'd250)
`endif

// ===== logic/lpt_pkg.sv
package lpt_pkg;
    typedef enum logic [1:0] {LOC_NONE = 2'h0, LOC_LINE = 2'h1, LOC_PAY = 2'h2} lpt_loc_t;
    typedef enum logic [2:0] {
        REM_NONE = 3'h0, REM_V54 = 3'h1, REM_INB_LLB = 3'h2, REM_FDL_LLB = 3'h3,
        REM_FDL_PLB = 3'h4
    } lpt_rem_t;
    typedef enum logic [2:0] {
        PAT_NONE = 3'h0, PAT_1IN8 = 3'h1, PAT_PRBS = 3'h2, PAT_ZERO = 3'h3, PAT_ONES = 3'h4
    } lpt_pat_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_MEM = 5'h02, ST_LOOP = 5'h04, ST_LED = 5'h08, ST_PLL = 5'h10
    } lpt_st_t;
    typedef struct packed {
        logic        clk1, clk2, clk3, rxd1, rxd2, fs1, fs2, dtd1, dtd2;
        logic        mem1, mem2, pll1, pll2;
        lpt_loc_t    loc;
        lpt_rem_t    rem;
        lpt_rem_t    rel_kind;
        lpt_pat_t    pat;
        logic        dte_loop, rate64, frac;
        logic [4:0]  start, nchan;
        logic [7:0]  pos;
        logic        frame_odd, fbit;
        logic [3:0]  fdl_idx;
        logic [8:0]  gen, chk;
        logic [4:0]  good;
        logic        sync, ins_pend;
        logic [31:0] err_tot;
        logic [7:0]  rel_cnt;
        lpt_st_t     st;
        logic [31:0] st_cnt;
        logic [2:0]  fail;
        logic        tx_bit, dte_rx, led, bsy;
        logic [31:0] rdata;
    } lpt_state_t;
endpackage : lpt_pkg

// ===== logic/lpt_test_core.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lpt_regs.svh"
module lpt_test_core #(
    parameter logic [31:0] ST_STEP = 32'(`LPT_ST_CYCLES / 64'd4)
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // network-side line, bit clock level and frame marker
    input  wire logic        line_clk,
    input  wire logic        line_rx_data,
    input  wire logic        line_rx_fsync,
    output logic             line_tx_data,
    // DTE synchronous data
    input  wire logic        dte_tx_data,
    output logic             dte_rx_data,
    // self-test inputs and indicator drive
    input  wire logic        mem_check_ok,
    input  wire logic        pll_locked,
    output logic             led_test,
    output logic             selftest_busy
);
    lpt_pkg::lpt_state_t s_r, s_nxt;

    function automatic logic chan_on(input logic [4:0] slot, input logic [4:0] st,
                                     input logic [4:0] n);
        logic [5:0] rel;
        rel = {1'b0, slot} + 6'h18 - {1'b0, st} + 6'h01;
        if (rel >= 6'h18) rel = rel - 6'h18;
        return rel < {1'b0, n};
    endfunction : chan_on

    function automatic lpt_pkg::lpt_rem_t eff_rem(input lpt_pkg::lpt_rem_t r,
                                                   input logic frac);
        if (frac && (r == lpt_pkg::REM_FDL_LLB || r == lpt_pkg::REM_FDL_PLB))
            return lpt_pkg::REM_NONE;
        return r;
    endfunction : eff_rem

    logic       bit_en, busy, act, pay, gen_bit, pred, chk_in, wr_clr, wr_ins, wr_st;
    logic [7:0] cur_pos, pidx;
    logic [4:0] slot;
    logic [2:0] bitn;
    logic [7:0] code8;
    logic [15:0] code16;
    logic       fdl_on, inb_on, v54_on, rel;
    lpt_pkg::lpt_rem_t rk;

    always_comb begin
        s_nxt   = s_r;
        // two-stage synchronisers on every line, DTE and self-test input; the register port is used as is
        s_nxt.clk1 = line_clk;
        s_nxt.clk2 = s_r.clk1;
        s_nxt.clk3 = s_r.clk2;
        s_nxt.rxd1 = line_rx_data;
        s_nxt.rxd2 = s_r.rxd1;
        s_nxt.fs1  = line_rx_fsync;
        s_nxt.fs2  = s_r.fs1;
        s_nxt.dtd1 = dte_tx_data;
        s_nxt.dtd2 = s_r.dtd1;
        s_nxt.mem1 = mem_check_ok;
        s_nxt.mem2 = s_r.mem1;
        s_nxt.pll1 = pll_locked;
        s_nxt.pll2 = s_r.pll1;

        bit_en  = s_r.clk2 & ~s_r.clk3;
        busy    = s_r.st != lpt_pkg::ST_IDLE;
        cur_pos = s_r.fs2 ? 8'h00 : s_r.pos;
        pidx    = cur_pos - 8'h01;
        pay     = cur_pos != 8'h00;
        slot    = pidx[7:3];
        bitn    = pidx[2:0];
        // 56K base rate leaves the last bit of each channel unused
        act     = pay && chan_on(slot, s_r.start, s_r.nchan)
                  && (s_r.rate64 || bitn != 3'h7);
        gen_bit = s_r.gen[8] ^ s_r.gen[4];
        pred    = s_r.chk[8] ^ s_r.chk[4];

        wr_clr = reg_wr && reg_addr == `LPT_REG_CMD && reg_wdata[`LPT_CMD_CLR_BIT];
        wr_ins = reg_wr && reg_addr == `LPT_REG_CMD && reg_wdata[`LPT_CMD_INS_BIT];
        wr_st  = reg_wr && reg_addr == `LPT_REG_CMD && reg_wdata[`LPT_CMD_ST_BIT];

        // remote loop: active request or release after it is dropped
        rel    = s_r.rel_cnt != 8'h00;
        rk     = rel ? s_r.rel_kind : eff_rem(s_r.rem, s_r.frac);
        fdl_on = rk == lpt_pkg::REM_FDL_LLB || rk == lpt_pkg::REM_FDL_PLB;
        inb_on = rk == lpt_pkg::REM_INB_LLB;
        v54_on = rk == lpt_pkg::REM_V54;
        code8  = inb_on ? (rel ? `LPT_INB_DN : `LPT_INB_UP)
                        : (rel ? `LPT_V54_DN : `LPT_V54_UP);
        code16 = rel ? `LPT_FDL_DN
                     : (rk == lpt_pkg::REM_FDL_LLB ? `LPT_FDL_LLB_UP : `LPT_FDL_PLB_UP);

        // register writes
        if (reg_wr && reg_addr == `LPT_REG_CTRL) begin
            s_nxt.loc      = lpt_pkg::lpt_loc_t'(reg_wdata[`LPT_CTRL_LOC_LSB +: 2]);
            s_nxt.rem      = lpt_pkg::lpt_rem_t'(reg_wdata[`LPT_CTRL_REM_LSB +: 3]);
            s_nxt.pat      = lpt_pkg::lpt_pat_t'(reg_wdata[`LPT_CTRL_PAT_LSB +: 3]);
            s_nxt.dte_loop = reg_wdata[`LPT_CTRL_DTE_BIT];
            s_nxt.rate64   = reg_wdata[`LPT_CTRL_R64_BIT];
            s_nxt.frac     = reg_wdata[`LPT_CTRL_FRAC_BIT];
            // far end is only released by dropping the request
            if (reg_wdata[`LPT_CTRL_REM_LSB +: 3] == 3'h0
                && eff_rem(s_r.rem, s_r.frac) != lpt_pkg::REM_NONE) begin
                s_nxt.rel_kind = eff_rem(s_r.rem, s_r.frac);
                s_nxt.rel_cnt  = `LPT_REL_FRAMES;
            end else if (reg_wdata[`LPT_CTRL_REM_LSB +: 3] != 3'h0) begin
                s_nxt.rel_cnt = 8'h00;
            end
        end
        if (reg_wr && reg_addr == `LPT_REG_CHAN) begin
            s_nxt.start = reg_wdata[`LPT_CHAN_ST_LSB +: 5];
            s_nxt.nchan = reg_wdata[`LPT_CHAN_N_LSB +: 5];
        end
        // line bit processing
        if (bit_en && s_r.st != lpt_pkg::ST_LOOP) begin
            s_nxt.pos = (cur_pos == `LPT_LAST_POS) ? 8'h00 : cur_pos + 8'h01;
            if (!pay) begin
                s_nxt.frame_odd = ~s_r.frame_odd;
                if (!s_r.frame_odd)
                    s_nxt.fbit = ~s_r.fbit;
                else
                    s_nxt.fdl_idx = s_r.fdl_idx + 4'h1;
                if (rel && s_r.frame_odd)
                    s_nxt.rel_cnt = s_r.rel_cnt - 8'h01;
            end
            // checker runs whatever the generator does
            if (act) begin
                chk_in = s_r.rxd2;
                if (!s_r.sync) begin
                    s_nxt.chk  = {s_r.chk[7:0], chk_in};
                    s_nxt.good = (chk_in == pred) ? s_r.good + 5'h01 : 5'h00;
                    if (chk_in == pred && s_r.good == `LPT_SYNC_GOOD - 5'h01)
                        s_nxt.sync = 1'b1;
                end else begin
                    s_nxt.chk = {s_r.chk[7:0], pred};
                    if (chk_in != pred) begin
                        if (s_r.err_tot != 32'hffffffff)
                            s_nxt.err_tot = s_r.err_tot + 32'h1;
                        s_nxt.good = s_r.good + 5'h01;
                        if (s_r.good == `LPT_SYNC_LOSS - 5'h01) begin
                            s_nxt.sync = 1'b0;
                            s_nxt.good = 5'h00;
                        end
                    end else begin
                        s_nxt.good = 5'h00;
                    end
                end
            end
            // transmit selection
            if (busy) begin
                s_nxt.tx_bit = 1'b1;
            end else if (s_r.loc == lpt_pkg::LOC_LINE) begin
                s_nxt.tx_bit = s_r.rxd2;
            end else if (!pay) begin
                // framing and data link regenerated locally
                if (!s_r.frame_odd)
                    s_nxt.tx_bit = s_r.fbit;
                else
                    s_nxt.tx_bit = fdl_on ? code16[s_r.fdl_idx] : 1'b1;
            end else if (s_r.loc == lpt_pkg::LOC_PAY) begin
                s_nxt.tx_bit = s_r.rxd2;
            end else begin
                case (s_r.pat)
                    lpt_pkg::PAT_1IN8: s_nxt.tx_bit = bitn == 3'h0;
                    lpt_pkg::PAT_ZERO: s_nxt.tx_bit = 1'b0;
                    lpt_pkg::PAT_ONES: s_nxt.tx_bit = 1'b1;
                    lpt_pkg::PAT_PRBS: begin
                        if (act) begin
                            s_nxt.gen      = {s_r.gen[7:0], gen_bit};
                            s_nxt.tx_bit   = gen_bit ^ s_r.ins_pend;
                            s_nxt.ins_pend = 1'b0;
                        end else begin
                            s_nxt.tx_bit = 1'b1;
                        end
                    end
                    default: begin
                        // code words go out most significant bit first
                        if (inb_on)
                            s_nxt.tx_bit = code8[3'h7 - bitn];
                        else if (act && v54_on)
                            s_nxt.tx_bit = code8[3'h7 - bitn];
                        else if (act)
                            s_nxt.tx_bit = s_r.dtd2;
                        else
                            s_nxt.tx_bit = 1'b1;
                    end
                endcase
            end
            if (act && !busy && !s_r.dte_loop)
                s_nxt.dte_rx = s_r.rxd2;
        end
        // insert request taken after the transmit step so a same-cycle command is kept
        if (wr_ins && s_r.pat == lpt_pkg::PAT_PRBS)
            s_nxt.ins_pend = 1'b1;
        if (busy)
            s_nxt.dte_rx = 1'b1;
        else if (s_r.dte_loop)
            s_nxt.dte_rx = s_r.dtd2;

        // error total clear; a counted error in the same cycle survives
        if (wr_clr)
            s_nxt.err_tot = (s_nxt.err_tot != s_r.err_tot) ? 32'h1 : 32'h0;

        // self-test sequence
        s_nxt.st_cnt = s_r.st_cnt + 32'h1;
        s_nxt.led    = s_r.st == lpt_pkg::ST_LED;
        case (s_r.st)
            lpt_pkg::ST_IDLE: begin
                s_nxt.st_cnt = 32'h0;
                if (wr_st) begin
                    s_nxt.st   = lpt_pkg::ST_MEM;
                    s_nxt.fail = 3'h0;
                end
            end
            lpt_pkg::ST_MEM: if (s_r.st_cnt == ST_STEP - 32'h1) begin
                if (!s_r.mem2 && s_r.fail == 3'h0)
                    s_nxt.fail = 3'h1;
                s_nxt.st     = lpt_pkg::ST_LOOP;
                s_nxt.st_cnt = 32'h0;
                s_nxt.sync   = 1'b0;
                s_nxt.good   = 5'h00;
                s_nxt.gen    = 9'h1ff;
                s_nxt.chk    = 9'h000;
            end
            lpt_pkg::ST_LOOP: begin
                // generator fed straight into the checker on board
                s_nxt.gen = {s_r.gen[7:0], gen_bit};
                s_nxt.chk = {s_r.chk[7:0], gen_bit};
                if (gen_bit == pred && s_r.good != `LPT_SYNC_GOOD)
                    s_nxt.good = s_r.good + 5'h01;
                if (s_r.st_cnt == ST_STEP - 32'h1) begin
                    if (s_r.good != `LPT_SYNC_GOOD && s_r.fail == 3'h0)
                        s_nxt.fail = 3'h2;
                    s_nxt.st     = lpt_pkg::ST_LED;
                    s_nxt.st_cnt = 32'h0;
                    s_nxt.good   = 5'h00;
                end
            end
            lpt_pkg::ST_LED: if (s_r.st_cnt == ST_STEP - 32'h1) begin
                s_nxt.st     = lpt_pkg::ST_PLL;
                s_nxt.st_cnt = 32'h0;
            end
            lpt_pkg::ST_PLL: if (s_r.st_cnt == ST_STEP - 32'h1) begin
                if (!s_r.pll2 && s_r.fail == 3'h0)
                    s_nxt.fail = 3'h4;
                s_nxt.st     = lpt_pkg::ST_IDLE;
                s_nxt.st_cnt = 32'h0;
            end
            default: s_nxt.st = lpt_pkg::ST_IDLE;
        endcase
        s_nxt.bsy = s_nxt.st != lpt_pkg::ST_IDLE;

        // read data, one cycle after the strobe
        s_nxt.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `LPT_REG_CTRL: s_nxt.rdata = {21'h0, s_r.frac, s_r.rate64, s_r.dte_loop,
                                              s_r.pat, s_r.rem, s_r.loc};
                `LPT_REG_CHAN: s_nxt.rdata = {19'h0, s_r.nchan, 3'h0, s_r.start};
                `LPT_REG_ERRS: s_nxt.rdata = s_r.err_tot;
                `LPT_REG_STAT: s_nxt.rdata = {13'h0,
                    11'(s_r.nchan) * (s_r.rate64 ? 11'h040 : 11'h038),
                    3'h0, s_r.sync, s_r.fail, busy};
                default:       s_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.start    <= `LPT_RST_START;
            s_r.nchan    <= `LPT_RST_NCHAN;
            s_r.gen      <= 9'h1ff;
            s_r.st       <= lpt_pkg::ST_MEM;
            s_r.tx_bit   <= 1'b1;
            s_r.dte_rx   <= 1'b1;
            s_r.bsy      <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata     = s_r.rdata;
    assign line_tx_data  = s_r.tx_bit;
    assign dte_rx_data   = s_r.dte_rx;
    assign led_test      = s_r.led;
    assign selftest_busy = s_r.bsy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic pay_gen;
    assign pay_gen = bit_en && !busy && s_r.loc == lpt_pkg::LOC_NONE && pay;

    clear_total_a: assert property (wr_clr && !(bit_en && act && s_r.sync)
        |=> s_r.err_tot == 32'h0) else $error("error total not cleared");
    total_grows_a: assert property (!wr_clr |=> s_r.err_tot >= $past(s_r.err_tot))
        else $error("error total went down");
    line_loop_a: assert property (bit_en && !busy && s_r.loc == lpt_pkg::LOC_LINE
        |=> line_tx_data == $past(s_r.rxd2)) else $error("line loop not transparent");
    zeros_a: assert property (pay_gen && s_r.pat == lpt_pkg::PAT_ZERO
        |=> !line_tx_data) else $error("zeros pattern sent a one");
    ones_a: assert property (pay_gen && s_r.pat == lpt_pkg::PAT_ONES
        |=> line_tx_data) else $error("ones pattern sent a zero");
    one_in_eight_a: assert property (pay_gen && s_r.pat == lpt_pkg::PAT_1IN8
        |=> line_tx_data == ($past(bitn) == 3'h0)) else $error("one in eight wrong");
    selftest_run_a: assert property (!busy && wr_st
        |=> selftest_busy [*8]) else $error("self-test did not start");
    selftest_idle_a: assert property (busy && bit_en
        |=> line_tx_data && dte_rx_data) else $error("data passed during self-test");
    dte_loop_a: assert property (s_r.dte_loop && !busy
        |=> dte_rx_data == $past(s_r.dtd2)) else $error("DTE loop wrong");
    insert_once_a: assert property (pay_gen && s_r.pat == lpt_pkg::PAT_PRBS && act
        && s_r.ins_pend && !wr_ins |=> !s_r.ins_pend && line_tx_data != $past(gen_bit))
        else $error("error insert not applied once");
endmodule : lpt_test_core
`default_nettype wire

// ===== tb/lpt_span_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpt_span_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // far end looped back when high
    input  wire logic       loop_far,
    // line toward and from the unit
    input  wire logic       line_tx_data,
    output logic            line_clk,
    output logic            line_rx_data,
    output logic            line_rx_fsync,
    // observed transmit bit and its frame position
    output logic            obs_valid,
    output logic [7:0]      obs_pos,
    output logic            obs_bit
);
    logic [2:0] ph;
    logic [7:0] pos;
    logic       mem [0:192];

    // data settles two cycles before the bit clock rises, eight cycles per bit
    assign line_clk      = (ph >= 3'h2) && (ph < 3'h6);
    assign line_rx_fsync = (pos == 8'h00);
    // looped far end returns last frame's bit at the same position
    assign line_rx_data  = loop_far ? mem[pos] : pos[0];

    always_ff @(posedge clk) begin
        obs_valid <= 1'b0;
        if (rst) begin
            ph  <= 3'h0;
            pos <= 8'h00;
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                mem[pos]  <= line_tx_data;
                obs_valid <= 1'b1;
                obs_pos   <= pos;
                obs_bit   <= line_tx_data;
                pos       <= (pos == 8'hc0) ? 8'h00 : pos + 8'h01;
            end
        end
    end
endmodule : lpt_span_model
`default_nettype wire

// ===== tb/t1_loopback_pattern_test_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lpt_regs.svh"
module t1_loopback_pattern_test_tb;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic        line_clk, line_rx_data, line_rx_fsync, line_tx_data;
    logic        dte_tx_data = 1'b1, mem_check_ok = 1'b1, pll_locked = 1'b1;
    logic        dte_rx_data, led_test, selftest_busy, loop_far = 1'b0, led_seen = 1'b0;
    logic        obs_valid, obs_bit;
    logic [7:0]  obs_pos;
    logic        fr [0:192];
    int          n_errors = 0, cmp_count = 0;

    always #2 clk = ~clk;

    lpt_test_core #(.ST_STEP(32'd64)) u_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_clk(line_clk),
        .line_rx_data(line_rx_data), .line_rx_fsync(line_rx_fsync),
        .line_tx_data(line_tx_data), .dte_tx_data(dte_tx_data), .dte_rx_data(dte_rx_data),
        .mem_check_ok(mem_check_ok), .pll_locked(pll_locked), .led_test(led_test),
        .selftest_busy(selftest_busy));

    lpt_span_model u_span (
        .clk(clk), .rst(rst), .loop_far(loop_far), .line_tx_data(line_tx_data),
        .line_clk(line_clk), .line_rx_data(line_rx_data), .line_rx_fsync(line_rx_fsync),
        .obs_valid(obs_valid), .obs_pos(obs_pos), .obs_bit(obs_bit));

    task summarize;
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task hang;
        n_errors++;
        summarize;
    endtask : hang

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // collect one whole frame of transmitted bits, positions 0..192
    task frame;
        int k;
        for (k = 0; k < 4000 && !(obs_valid && obs_pos == 8'hc0); k++) @(posedge clk);
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (obs_valid) fr[obs_pos] = obs_bit;
        end while (!(obs_valid && obs_pos == 8'hc0) && k < 4000);
        if (k >= 4000) hang;
    endtask : frame

    function automatic logic [7:0] chan(input int c);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) b[7 - i] = fr[8 * c + 1 + i];
        return b;
    endfunction : chan

    task wait_idle;
        int k;
        for (k = 0; k < 2000 && selftest_busy !== 1'b0; k++) begin
            @(posedge clk);
            if (led_test === 1'b1) led_seen = 1'b1;
        end
        if (k >= 2000) hang;
    endtask : wait_idle

    task set_ctrl(input logic [2:0] rem, input lpt_pkg::lpt_loc_t loc, input logic [2:0] pat);
        wr(`LPT_REG_CTRL, 32'h200 | (32'(pat) << 5) | (32'(rem) << 2) | 32'(loc));
        frame;
    endtask : set_ctrl

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check(32'(selftest_busy), 32'h1);
        check(32'(line_tx_data), 32'h1);
        wait_idle;
        check(32'(led_seen), 32'h1);
        rd(`LPT_REG_STAT);
        check(d[3:0], 32'h0);
        for (int b = 0; b < 2; b++) begin
            wr(`LPT_REG_CTRL, 32'(b) << 9);
            for (int n = 1; n <= 24; n++) begin
                wr(`LPT_REG_CHAN, (32'(n) << 8) | 32'h1);
                rd(`LPT_REG_STAT);
                check(32'(d[18:8]), 32'(n * (b ? 64 : 56)));
            end
        end
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_ZERO);
        for (int c = 0; c < 24; c++) check(32'(chan(c)), 32'h0);
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_ONES);
        for (int c = 0; c < 24; c++) check(32'(chan(c)), 32'hff);
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_1IN8);
        for (int c = 0; c < 24; c++) check(32'($countones(chan(c))), 32'h1);
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_NONE);
        for (int c = 0; c < 24; c++) check(32'(chan(c)), 32'hff);
        // line and payload loops echo the alternating span pattern
        set_ctrl(3'h0, lpt_pkg::LOC_LINE, lpt_pkg::PAT_NONE);
        check(32'(fr[0]), 32'h0);
        for (int c = 0; c < 24; c++) check(32'(chan(c)), 32'haa);
        set_ctrl(3'h0, lpt_pkg::LOC_PAY, lpt_pkg::PAT_NONE);
        for (int c = 0; c < 24; c++) check(32'(chan(c)), 32'haa);
        // two active channels starting at channel 3
        wr(`LPT_REG_CHAN, 32'h0203);
        set_ctrl(3'h1, lpt_pkg::LOC_NONE, lpt_pkg::PAT_NONE);
        check(32'(chan(2)), 32'(`LPT_V54_UP));
        check(32'(chan(0)), 32'hff);
        set_ctrl(3'h2, lpt_pkg::LOC_NONE, lpt_pkg::PAT_NONE);
        check(32'(chan(9)), 32'(`LPT_INB_UP));
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_NONE);
        check(32'(chan(9)), 32'(`LPT_INB_DN));
        loop_far <= 1'b1;
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_PRBS);
        for (int c = 0; c < 24; c++) if (c < 2 || c > 3) check(32'(chan(c)), 32'hff);
        frame;
        frame;
        rd(`LPT_REG_STAT);
        check(32'(d[4]), 32'h1);
        wr(`LPT_REG_CMD, 32'h1);
        frame;
        rd(`LPT_REG_ERRS);
        check(d, 32'h0);
        for (int i = 1; i <= 2; i++) begin
            wr(`LPT_REG_CMD, 32'h2);
            frame;
            frame;
            rd(`LPT_REG_ERRS);
            check(d, 32'(i));
        end
        wr(`LPT_REG_CMD, 32'h1);
        rd(`LPT_REG_ERRS);
        check(d, 32'h0);
        loop_far <= 1'b0;
        wr(`LPT_REG_CTRL, 32'h100);
        dte_tx_data <= 1'b0;
        repeat (8) @(posedge clk);
        check(32'(dte_rx_data), 32'h0);
        set_ctrl(3'h0, lpt_pkg::LOC_NONE, lpt_pkg::PAT_ZERO);
        pll_locked <= 1'b0;
        wr(`LPT_REG_CMD, 32'h4);
        repeat (20) @(posedge clk);
        check(32'(line_tx_data), 32'h1);
        check(32'(selftest_busy), 32'h1);
        wait_idle;
        rd(`LPT_REG_STAT);
        check(32'(d[3:1]), 32'h4);
        summarize;
    end
endmodule : t1_loopback_pattern_test_tb
`default_nettype wire
